// ===== rtl/dsc_top.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`include "dsc_defines.svh"
// dram setup configuration registers behind an ahb-lite slave
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned CNT_W = 14,
    parameter int unsigned RFSH_15_CYC =
        `DSC_RFSH_15_NS / `DSC_CLK_PERIOD_NS,
    parameter int unsigned RFSH_30_CYC =
        `DSC_RFSH_30_NS / `DSC_CLK_PERIOD_NS,
    parameter int unsigned RFSH_61_CYC =
        `DSC_RFSH_61_NS / `DSC_CLK_PERIOD_NS,
    parameter int unsigned RFSH_122_CYC =
        `DSC_RFSH_122_NS / `DSC_CLK_PERIOD_NS
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // 1 write
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic l2_cache_en, // second-level cache fitted
    output logic mapping_en, // simplified mapping on
    output logic parity_check_en, // parity checking active
    output logic [14:0] bank_size, // 3 bits per bank
    output logic [4:0] bank_installed, // bank present
    output logic [4:0] bank_asym, // effective asymmetry
    output logic [9:0] bank_geom, // 2 bits per bank
    output logic [1:0] std_read_wait, // standard read timing
    output logic [1:0] write_wait, // write timing code
    output logic early_ras, // row strobe half clock early
    output logic heavy_drive, // heavy-duty bus drive
    output logic refresh_en, // refresh generation on
    output logic [1:0] refresh_rate, // interval select
    output logic refresh_req // one-cycle refresh tick
);
    logic [7:0] regs [`DSC_NUM_REGS];
    logic wr_pend;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic addr_ok;
    logic [7:0] rd_val;
    logic [CNT_W-1:0] rfsh_cnt;
    logic [CNT_W-1:0] rfsh_last;
    logic [2:0] sz [`DSC_NUM_BANKS];
    logic [`DSC_NUM_BANKS-1:0] typ;
    logic [`DSC_NUM_BANKS-1:0] inst_c;
    logic [`DSC_NUM_BANKS-1:0] asym_c;
    dsc_geom_e geom_c [`DSC_NUM_BANKS];

    // maps a register index to its storage slot
    function automatic logic [3:0] slot_of(input logic [7:0] idx);
        case (idx)
            `DSC_IDX_PARITY: slot_of = `DSC_SLOT_PARITY;
            `DSC_IDX_TIMING: slot_of = `DSC_SLOT_TIMING;
            `DSC_IDX_RFSH_EN: slot_of = `DSC_SLOT_RFSH_EN;
            `DSC_IDX_RFSH_RATE: slot_of = `DSC_SLOT_RFSH_RATE;
            `DSC_IDX_MAP: slot_of = `DSC_SLOT_MAP;
            `DSC_IDX_DRIVE: slot_of = `DSC_SLOT_DRIVE;
            `DSC_IDX_BANK01: slot_of = `DSC_SLOT_BANK01;
            `DSC_IDX_BANK23: slot_of = `DSC_SLOT_BANK23;
            `DSC_IDX_BANK4: slot_of = `DSC_SLOT_BANK4;
            `DSC_IDX_GEOM: slot_of = `DSC_SLOT_GEOM;
            default: slot_of = `DSC_SLOT_NONE;
        endcase
    endfunction : slot_of

    // reset value of a slot
    function automatic logic [7:0] rst_of(input int unsigned s);
        if (4'(s) == `DSC_SLOT_TIMING) begin
            rst_of = `DSC_RST_TIMING;
        end else begin
            rst_of = `DSC_RST_OTHER;
        end
    endfunction : rst_of

    // address phase decode; only word-aligned addresses in the low space hit, hsize is not checked
    always_comb begin
        addr_ok = (haddr[31:`DSC_ADDR_MSB+1] == '0) &&
            (haddr[`DSC_ADDR_LSB-1:0] == '0);
        if (addr_ok) begin
            rd_slot = slot_of(haddr[`DSC_ADDR_MSB:`DSC_ADDR_LSB]);
        end else begin
            rd_slot = `DSC_SLOT_NONE;
        end
    end

    // capture a write address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_slot <= `DSC_SLOT_NONE;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_slot <= rd_slot;
        end
    end

    // register storage, written in the data phase
    for (genvar g = 0; g < `DSC_NUM_REGS; g++) begin : g_reg
        localparam logic [7:0] RST = rst_of(g);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                regs[g] <= RST;
            end else if (wr_pend && wr_slot == 4'(g)) begin
                regs[g] <= hwdata[7:0];
            end
        end
    end

    // read value with forwarding of a write still in its data phase
    always_comb begin
        if (rd_slot == `DSC_SLOT_NONE) begin
            rd_val = 8'h00;
        end else if (wr_pend && wr_slot == rd_slot) begin
            rd_val = hwdata[7:0];
        end else begin
            rd_val = regs[rd_slot];
        end
    end

    // bus answers: zero wait, always okay, unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= {24'h0, rd_val};
        end
    end

    // per-bank field extraction: even banks low nibble, odd high
    for (genvar b = 0; b < `DSC_NUM_BANKS; b++) begin : g_bank
        localparam logic [3:0] SLOT = `DSC_SLOT_BANK01 + 4'(b / 2);
        if (b % 2 == 0) begin : g_lo
            assign sz[b] =
                regs[SLOT][`DSC_LO_SIZE_HI:`DSC_LO_SIZE_LO];
            assign typ[b] = regs[SLOT][`DSC_LO_TYPE_BIT];
        end else begin : g_hi
            assign sz[b] =
                regs[SLOT][`DSC_HI_SIZE_HI:`DSC_HI_SIZE_LO];
            assign typ[b] = regs[SLOT][`DSC_HI_TYPE_BIT];
        end
        dsc_bank_cfg u_cfg (
            .size(sz[b]),
            .asym_type(typ[b]),
            .geom_sel(regs[`DSC_SLOT_GEOM][b]),
            .installed(inst_c[b]),
            .asym_eff(asym_c[b]),
            .geom(geom_c[b])
        );
        // registered bank outputs
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                bank_size[3*b +: 3] <= `DSC_SIZE_NONE;
                bank_installed[b] <= 1'b0;
                bank_asym[b] <= 1'b0;
                bank_geom[2*b +: 2] <= DSC_GEOM_SYM;
            end else begin
                bank_size[3*b +: 3] <= sz[b];
                bank_installed[b] <= inst_c[b];
                bank_asym[b] <= asym_c[b];
                bank_geom[2*b +: 2] <= geom_c[b];
            end
        end
    end

    // mapping, parity and drive controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mapping_en <= 1'b0;
            parity_check_en <= 1'b0;
            heavy_drive <= 1'b0;
        end else begin
            mapping_en <= regs[`DSC_SLOT_MAP][`DSC_MAP_EN_BIT];
            parity_check_en <= !l2_cache_en &&
                !regs[`DSC_SLOT_PARITY][`DSC_PAR_DIS_BIT];
            heavy_drive <= regs[`DSC_SLOT_DRIVE][`DSC_DRIVE_BIT];
        end
    end

    // cycle speed; the read field serves standard dram banks only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            std_read_wait <= 2'(`DSC_RST_TIMING >> `DSC_RD_LO);
            write_wait <= `DSC_WR_EARLY;
            early_ras <= 1'b1;
        end else begin
            std_read_wait <=
                regs[`DSC_SLOT_TIMING][`DSC_RD_HI:`DSC_RD_LO];
            write_wait <=
                regs[`DSC_SLOT_TIMING][`DSC_WR_HI:`DSC_WR_LO];
            early_ras <= regs[`DSC_SLOT_TIMING][`DSC_WR_HI:`DSC_WR_LO]
                == `DSC_WR_EARLY;
        end
    end

    // selected interval, last count of the tick divider
    always_comb begin
        case (regs[`DSC_SLOT_RFSH_RATE][`DSC_RATE_HI:`DSC_RATE_LO])
            `DSC_RATE_15: rfsh_last = CNT_W'(RFSH_15_CYC - 1);
            `DSC_RATE_30: rfsh_last = CNT_W'(RFSH_30_CYC - 1);
            `DSC_RATE_61: rfsh_last = CNT_W'(RFSH_61_CYC - 1);
            default: rfsh_last = CNT_W'(RFSH_122_CYC - 1);
        endcase
    end

    // refresh tick divider, held clear while refresh is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rfsh_cnt <= '0;
            refresh_req <= 1'b0;
            refresh_en <= 1'b0;
            refresh_rate <= `DSC_RATE_15;
        end else begin
            refresh_en <= regs[`DSC_SLOT_RFSH_EN][`DSC_RFSH_EN_BIT];
            refresh_rate <=
                regs[`DSC_SLOT_RFSH_RATE][`DSC_RATE_HI:`DSC_RATE_LO];
            if (!regs[`DSC_SLOT_RFSH_EN][`DSC_RFSH_EN_BIT]) begin
                rfsh_cnt <= '0;
                refresh_req <= 1'b0;
            end else if (rfsh_cnt >= rfsh_last) begin
                rfsh_cnt <= '0;
                refresh_req <= 1'b1;
            end else begin
                rfsh_cnt <= rfsh_cnt + 1'b1;
                refresh_req <= 1'b0;
            end
        end
    end

    // checker helpers: big-bank mask and tick spacing
    logic [4:0] big_mask;
    logic [CNT_W-1:0] since;
    logic since_ok;
    logic [CNT_W-1:0] last_q;
    always_comb begin
        for (int i = 0; i < `DSC_NUM_BANKS; i++) begin
            big_mask[i] = bank_size[3*i +: 3] >= `DSC_SIZE_32MB;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since <= '0;
            since_ok <= 1'b0;
            last_q <= '0;
        end else begin
            last_q <= rfsh_last;
            since <= refresh_req ? '0 : since + 1'b1;
            if (!refresh_en || last_q != rfsh_last) begin
                since_ok <= 1'b0;
            end else if (refresh_req) begin
                since_ok <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_map_wr;
        wr_pend && wr_slot == `DSC_SLOT_MAP |->
            ##2 mapping_en == $past(hwdata[`DSC_MAP_EN_BIT], 2);
    endproperty
    a_map_wr: assert property (p_map_wr)
        else $error("mapping enable does not follow write");

    property p_par_sel;
        wr_pend && wr_slot == `DSC_SLOT_PARITY &&
            hwdata[`DSC_PAR_DIS_BIT] |-> ##2 !parity_check_en;
    endproperty
    a_par_sel: assert property (p_par_sel)
        else $error("parity checking on after disable write");

    property p_par_l2;
        l2_cache_en |=> !parity_check_en;
    endproperty
    a_par_l2: assert property (p_par_l2)
        else $error("parity checking on with cache enabled");

    property p_bank_fields;
        wr_pend && wr_slot == `DSC_SLOT_BANK01 |-> ##2
            bank_size[2:0] == $past(hwdata[2:0], 2) &&
            bank_size[5:3] == $past(hwdata[6:4], 2);
    endproperty
    a_bank_fields: assert property (p_bank_fields)
        else $error("bank size fields misplaced");

    property p_big_sym;
        (bank_asym & big_mask) == 5'h0;
    endproperty
    a_big_sym: assert property (p_big_sym)
        else $error("large bank decoded asymmetric");

    property p_geom_asym;
        wr_pend && wr_slot == `DSC_SLOT_GEOM && bank_asym[0] &&
            $stable(bank_asym[0]) |-> ##2
            bank_geom[1:0] == ($past(hwdata[0], 2) ?
            DSC_GEOM_12X8 : DSC_GEOM_11X9) || !bank_asym[0];
    endproperty
    a_geom_asym: assert property (p_geom_asym)
        else $error("bank 0 geometry does not follow select");

    property p_timing;
        wr_pend && wr_slot == `DSC_SLOT_TIMING |-> ##2
            std_read_wait == $past(hwdata[7:6], 2) &&
            write_wait == $past(hwdata[5:4], 2);
    endproperty
    a_timing: assert property (p_timing)
        else $error("timing fields do not follow write");

    property p_early;
        early_ras == (write_wait == `DSC_WR_EARLY);
    endproperty
    a_early: assert property (p_early)
        else $error("early row strobe mismatch");

    property p_rfsh_gate;
        refresh_req |-> refresh_en;
    endproperty
    a_rfsh_gate: assert property (p_rfsh_gate)
        else $error("refresh tick while refresh disabled");

    // a tick is decided one cycle early, so it is held against last_q
    property p_rfsh_period;
        refresh_req && since_ok |-> since == last_q;
    endproperty
    a_rfsh_period: assert property (p_rfsh_period)
        else $error("refresh interval wrong");

    property p_drive;
        wr_pend && wr_slot == `DSC_SLOT_DRIVE |->
            ##2 heavy_drive == $past(hwdata[`DSC_DRIVE_BIT], 2);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive select does not follow write");

    c_map_on: cover property (mapping_en);
    c_rfsh: cover property (refresh_req && since_ok);
    c_early: cover property (early_ras && heavy_drive);
    c_geom: cover property (bank_geom[1:0] == DSC_GEOM_12X8);
endmodule : dsc_top

// ===== shared/dsc_defines.svh
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// register indices; the byte address is four times the index
`define DSC_IDX_PARITY 8'h31
`define DSC_IDX_TIMING 8'h35
`define DSC_IDX_RFSH_EN 8'h57
`define DSC_IDX_RFSH_RATE 8'h67
`define DSC_IDX_MAP 8'ha0
`define DSC_IDX_DRIVE 8'ha1
`define DSC_IDX_BANK01 8'ha8
`define DSC_IDX_BANK23 8'ha9
`define DSC_IDX_BANK4 8'haa
`define DSC_IDX_GEOM 8'hd3
`define DSC_ADDR_LSB 2
`define DSC_ADDR_MSB 9

// storage slots
`define DSC_NUM_REGS 10
`define DSC_SLOT_PARITY 4'h0
`define DSC_SLOT_TIMING 4'h1
`define DSC_SLOT_RFSH_EN 4'h2
`define DSC_SLOT_RFSH_RATE 4'h3
`define DSC_SLOT_MAP 4'h4
`define DSC_SLOT_DRIVE 4'h5
`define DSC_SLOT_BANK01 4'h6
`define DSC_SLOT_BANK23 4'h7
`define DSC_SLOT_BANK4 4'h8
`define DSC_SLOT_GEOM 4'h9
`define DSC_SLOT_NONE 4'hf

// reset values
`define DSC_RST_TIMING 8'hff
`define DSC_RST_OTHER 8'h00

// field positions
`define DSC_MAP_EN_BIT 0
`define DSC_PAR_DIS_BIT 5
`define DSC_DRIVE_BIT 4
`define DSC_RFSH_EN_BIT 7
`define DSC_RATE_HI 6
`define DSC_RATE_LO 5
`define DSC_RD_HI 7
`define DSC_RD_LO 6
`define DSC_WR_HI 5
`define DSC_WR_LO 4
`define DSC_LO_SIZE_HI 2
`define DSC_LO_SIZE_LO 0
`define DSC_LO_TYPE_BIT 3
`define DSC_HI_SIZE_HI 6
`define DSC_HI_SIZE_LO 4
`define DSC_HI_TYPE_BIT 7

// codes
`define DSC_SIZE_NONE 3'h0
`define DSC_SIZE_32MB 3'h6
`define DSC_SIZE_64MB 3'h7
`define DSC_WR_EARLY 2'h3
`define DSC_RATE_15 2'h0
`define DSC_RATE_30 2'h1
`define DSC_RATE_61 2'h2

// timing
`define DSC_CLK_PERIOD_NS 10
`define DSC_RFSH_15_NS 15000
`define DSC_RFSH_30_NS 30000
`define DSC_RFSH_61_NS 61000
`define DSC_RFSH_122_NS 122000
`define DSC_NUM_BANKS 5
`endif

// ===== shared/dsc_pkg.sv
package dsc_pkg;
    // bank geometry as seen by the address decoder
    typedef enum logic [1:0] {
        DSC_GEOM_SYM = 2'h0,
        DSC_GEOM_11X9 = 2'h1,
        DSC_GEOM_12X8 = 2'h3
    } dsc_geom_e;
    typedef logic [2:0] dsc_size_t;
endpackage : dsc_pkg

// ===== rtl/dsc_bank_cfg.sv
`timescale 1ns/10ps
`include "dsc_defines.svh"
// resolves one bank's size, type and geometry bits
module dsc_bank_cfg
    import dsc_pkg::*;
(
    input wire dsc_size_t size, // size code
    input wire logic asym_type, // 1 asymmetric
    input wire logic geom_sel, // 1 selects 12x8
    output logic installed, // bank present
    output logic asym_eff, // asymmetric after override
    output dsc_geom_e geom // resolved geometry
);
    logic big;

    // large banks are always decoded symmetric
    always_comb begin
        big = (size == `DSC_SIZE_32MB) || (size == `DSC_SIZE_64MB);
        installed = (size != `DSC_SIZE_NONE);
        asym_eff = asym_type && !big && installed;
        if (!asym_eff) begin
            geom = DSC_GEOM_SYM;
        end else if (geom_sel) begin
            geom = DSC_GEOM_12X8;
        end else begin
            geom = DSC_GEOM_11X9;
        end
    end
endmodule : dsc_bank_cfg

// ===== test/dsc_dram_model.sv
`timescale 1ns/10ps
// dram bank side: takes refresh ticks and times their spacing
module dsc_dram_model (
    input wire logic hclk, // system clock
    input wire logic hresetn, // reset, active low
    input wire logic refresh_req, // refresh tick
    output int unsigned gap, // cycles between last two ticks
    output int unsigned ticks // refreshes taken
);
    int unsigned cnt;
    // each tick is counted in ticks and restarts the spacing count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            gap <= 0;
            ticks <= 0;
        end else if (refresh_req) begin
            gap <= cnt + 1;
            cnt <= 0;
            ticks <= ticks + 1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : dsc_dram_model

// ===== test/tb_top.sv
`timescale 1ns/10ps
`include "dsc_defines.svh"
module tb_top;
    localparam int unsigned per [4] = '{4, 6, 8, 10};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic l2_cache_en = 1'b0;
    logic hreadyout, hresp, mapping_en, parity_check_en, early_ras;
    logic heavy_drive, refresh_en, refresh_req, rd_dp = 1'b0;
    logic [31:0] hrdata, rnd;
    logic [14:0] bank_size;
    logic [4:0] bank_installed, bank_asym;
    logic [9:0] bank_geom;
    logic [1:0] std_read_wait, write_wait, refresh_rate;
    int unsigned gap, ticks, n;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 93;
    logic [31:0] rdq [$];
    logic [7:0] idx [10] = '{`DSC_IDX_PARITY, `DSC_IDX_TIMING,
        `DSC_IDX_RFSH_EN, `DSC_IDX_RFSH_RATE, `DSC_IDX_MAP,
        `DSC_IDX_DRIVE, `DSC_IDX_BANK01, `DSC_IDX_BANK23,
        `DSC_IDX_BANK4, `DSC_IDX_GEOM};
    logic [7:0] m [10] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int ord [10] = '{4, 5, 0, 6, 7, 8, 9, 1, 3, 2};

    // free-running clock
    always #5 hclk = ~hclk;

    dsc_top #(.RFSH_15_CYC(4), .RFSH_30_CYC(6), .RFSH_61_CYC(8),
        .RFSH_122_CYC(10)) i_dsc_top (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .l2_cache_en(l2_cache_en), .mapping_en(mapping_en),
        .parity_check_en(parity_check_en), .bank_size(bank_size),
        .bank_installed(bank_installed), .bank_asym(bank_asym),
        .bank_geom(bank_geom), .std_read_wait(std_read_wait),
        .write_wait(write_wait), .early_ras(early_ras),
        .heavy_drive(heavy_drive), .refresh_en(refresh_en),
        .refresh_rate(refresh_rate), .refresh_req(refresh_req));

    dsc_dram_model i_dsc_dram_model (.hclk(hclk), .hresetn(hresetn),
        .refresh_req(refresh_req), .gap(gap), .ticks(ticks));

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    // one single ahb-lite transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic wr,
        input logic [31:0] d);
        haddr <= {22'h0, a, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= !wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask : bus

    task automatic wr(input int s, input logic [31:0] d);
        bus(idx[s], 1'b1, d);
        m[s] = d[7:0];
    endtask : wr

    task automatic rd(input int s);
        rdq.push_back({24'h0, m[s]});
        bus(idx[s], 1'b0, 32'h0);
    endtask : rd

    // compare every configuration output with the register model
    task automatic ck_out;
        logic [14:0] sz;
        logic [4:0] ins, asy;
        logic [9:0] gm;
        logic [2:0] s;
        logic t;
        repeat (2) @(posedge hclk);
        #1;
        for (int b = 0; b < 5; b++) begin
            s = b[0] ? m[6 + b / 2][6:4] : m[6 + b / 2][2:0];
            t = b[0] ? m[6 + b / 2][7] : m[6 + b / 2][3];
            sz[3 * b +: 3] = s;
            ins[b] = (s != 3'h0);
            asy[b] = t && s != 3'h0 && s < 3'h6;
            gm[2 * b +: 2] = asy[b] ? (m[9][b] ? 2'h3 : 2'h1) : 2'h0;
        end
        chk("mapping_en", m[4][0], mapping_en);
        chk("parity", !l2_cache_en && !m[0][5], parity_check_en);
        chk("bank_size", sz, bank_size);
        chk("bank_installed", ins, bank_installed);
        chk("bank_asym", asy, bank_asym);
        chk("bank_geom", gm, bank_geom);
        chk("std_read_wait", m[1][7:6], std_read_wait);
        chk("write_wait", m[1][5:4], write_wait);
        chk("early_ras", m[1][5:4] == 2'h3, early_ras);
        chk("heavy_drive", m[5][4], heavy_drive);
        chk("refresh_en", m[2][7], refresh_en);
        chk("refresh_rate", m[3][6:5], refresh_rate);
        chk("hresp", 1'b0, hresp);
        chk("hreadyout", 1'b1, hreadyout);
        @(posedge hclk);
    endtask : ck_out

    // read data is taken at the data-phase edge
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk("hrdata", rdq.pop_front(), hrdata);
        end
    end

    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ck_out();
        for (int s = 0; s < 10; s++) begin
            rd(s);
        end
        // setup order: mapping, drive, parity, banks, geometry, speed, refresh
        repeat (10) begin
            rnd = $random(seed);
            l2_cache_en <= rnd[0];
            for (int i = 0; i < 10; i++) begin
                wr(ord[i], $random(seed));
                rd(ord[i]);
            end
            ck_out();
        end
        // every timing code and every size code with both types
        for (int c = 0; c < 16; c++) begin
            wr(1, {24'h0, c[3:0], 4'h5});
            wr(6, {24'h0, c[0], c[2:0], ~c[0], c[2:0]});
            wr(7, {24'h0, c[3:0], ~c[3:0]});
            wr(9, $random(seed));
            ck_out();
        end
        // unmapped index reads zero and ignores writes
        bus(8'h32, 1'b1, 32'hffff_ffff);
        rdq.push_back(32'h0);
        bus(8'h32, 1'b0, 32'h0);
        ck_out();
        // refresh spacing for each rate, and silence when disabled
        for (int r = 0; r < 4; r++) begin
            wr(2, 32'h0);
            wr(3, {25'h0, r[1:0], 5'h0});
            wr(2, 32'h80);
            repeat (40) @(negedge hclk);
            chk("refresh_gap", per[r], gap);
            @(posedge hclk);
            wr(2, 32'h0);
            ck_out();
            n = ticks;
            repeat (30) @(posedge hclk);
            chk("refresh_ticks", n, ticks);
        end
        stop_test();
    end
endmodule : tb_top
